// file: verilog/isl_cfg.svh
// Register offsets, field positions and reset values of the interrupt source block.
// Assumes inclusion by bare name wherever these constants are used.
`ifndef ISL_CFG_SVH
`define ISL_CFG_SVH
`define ISL_A_MAIN 8'h00
`define ISL_A_SECOND 8'h04
`define ISL_A_THIRD 8'h08
`define ISL_A_PFLG1 8'h0c
`define ISL_A_PEN1 8'h10
`define ISL_A_PPRI1 8'h14
`define ISL_A_PFLG2 8'h18
`define ISL_A_PEN2 8'h1c
`define ISL_A_PPRI2 8'h20
`define ISL_A_TLOW 8'h24
`define ISL_A_THIGH 8'h28
`define ISL_A_TCFG 8'h2c
`define ISL_A_ISTAT 8'h30
`define ISL_A_IMASK 8'h34
`define ISL_A_STATE 8'h38
// Main control fields
`define ISL_M_HIGH_LEVEL_GLOBAL_ENABLE 7
`define ISL_M_LOW_LEVEL_GLOBAL_ENABLE 6
`define ISL_M_T0IE 5
`define ISL_M_E0IE 4
`define ISL_M_PCIE 3
`define ISL_M_T0IF 2
`define ISL_M_E0IF 1
`define ISL_M_PCIF 0
// Second control fields
`define ISL_S_EDGE0 6
`define ISL_S_EDGE1 5
`define ISL_S_EDGE2 4
`define ISL_S_T0IP 2
`define ISL_S_PCIP 0
// Third control fields
`define ISL_T_E2IP 7
`define ISL_T_E1IP 6
`define ISL_T_E2IE 4
`define ISL_T_E1IE 3
`define ISL_T_E2IF 1
`define ISL_T_E1IF 0
// Timer config fields
`define ISL_C_ON 0
`define ISL_C_M16 1
// Reset values and masks
`define ISL_RST_MAIN 8'h00
`define ISL_RST_SECOND 8'h00
`define ISL_RST_THIRD 8'h00
`define ISL_RST_PERIPH 8'h00
`define ISL_PMASK1 8'h7f
`define ISL_PMASK2 8'h0f
`define ISL_T8_MAX 8'hff
`define ISL_T16_MAX 16'h0fff
`endif

// file: verilog/isl_pkg.sv
// Types shared by the interrupt source block.
// Assumes nothing beyond a SystemVerilog compiler.
package isl_pkg;
   typedef enum logic [1:0] {
      ISL_RESP_OKAY = 2'b00,
      ISL_RESP_SLVERR = 2'b10
   } isl_resp_t;
   typedef logic [7:0] isl_byte_t;
endpackage : isl_pkg

// file: verilog/isl_sync_edge.sv
// Two-flop synchroniser with edge and change detection for a group of pins.
// Assumes pins are asynchronous to aclk; level is registered on aclk, rise and fall are decoded from registers.
`timescale 1ns/100ps
module isl_sync_edge #(
   parameter int W = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] prev;

   if (W < 1) begin : g_bad
      $error("isl_sync_edge: W must be at least 1");
   end

   // First stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else if (ce) begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   // One pulse per transition since prev follows sync
   assign rise = sync & ~prev;
   assign fall = ~sync & prev;
endmodule : isl_sync_edge

// file: verilog/isl_top.sv
// Interrupt source logic: external edges, timer-0 overflow, port change,
// priority requests, wake-up and context capture, behind an AXI4-Lite slave.
// Assumes a single aclk domain; core signals are synchronous, pins are not.
`timescale 1ns/100ps
`include "isl_cfg.svh"
module isl_top #(
   parameter int AW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [2:0] ext_irq_pin,
   input wire logic [3:0] port_b_high,
   input wire logic timer_tick,
   input wire logic [6:0] periph_evt_one,
   input wire logic [3:0] periph_evt_two,
   input wire logic sleep_mode,
   input wire logic irq_ack,
   input wire logic [20:0] core_pc,
   input wire logic [7:0] working_register,
   input wire logic [7:0] core_status,
   input wire logic [7:0] bank_select_register,
   output logic irq_high_req,
   output logic irq_low_req,
   output logic wake_up,
   output logic vector_on_wake,
   output logic stack_push,
   output logic [20:0] stack_push_pc,
   output logic [7:0] fast_working,
   output logic [7:0] fast_status,
   output logic [7:0] fast_bank,
   output logic irq
);
   isl_pkg::isl_byte_t irq_control_main;
   isl_pkg::isl_byte_t irq_control_second;
   isl_pkg::isl_byte_t irq_control_third;
   isl_pkg::isl_byte_t periph_irq_flags_one;
   isl_pkg::isl_byte_t periph_irq_enables_one;
   isl_pkg::isl_byte_t periph_irq_priority_one;
   isl_pkg::isl_byte_t periph_irq_flags_two;
   isl_pkg::isl_byte_t periph_irq_enables_two;
   isl_pkg::isl_byte_t periph_irq_priority_two;
   logic [15:0] timer_zero_counter;
   logic [1:0] timer_cfg;
   logic [4:0] ev_stat;
   logic [4:0] ev_mask;
   logic [AW-1:0] wa;
   logic [31:0] wd;
   logic wb0;
   logic [2:0] ext_rise;
   logic [2:0] ext_fall;
   logic [3:0] port_level;
   logic [3:0] port_rise;
   logic [3:0] port_fall;
   logic [2:0] en_snap;
   logic sleep_prev;

   // Low byte decodes the map, so narrower buses cannot reach it
   if (AW < 8) begin : g_bad
      $error("isl_top: AW too small for the register map");
   end

   isl_sync_edge #(.W(3)) u_ext (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin(ext_irq_pin),
      .level(),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   isl_sync_edge #(.W(4)) u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin(port_b_high),
      .level(port_level),
      .rise(port_rise),
      .fall(port_fall)
   );

   // Write and event decode
   logic do_wr;
   logic wr_main;
   logic [2:0] edge_sel;
   logic [2:0] ext_hit;
   logic port_chg;
   logic t_on;
   logic t_m16;
   logic t_wr;
   logic t_wrap;
   logic t_ovf;
   logic [15:0] next_timer;
   logic [4:0] ev;

   assign do_wr = !awready && !wready && !bvalid;
   assign wr_main = do_wr && wb0 && wa[7:0] == `ISL_A_MAIN;
   assign edge_sel = {irq_control_second[`ISL_S_EDGE2], irq_control_second[`ISL_S_EDGE1],
                      irq_control_second[`ISL_S_EDGE0]};
   assign ext_hit = (edge_sel & ext_rise) | (~edge_sel & ext_fall);
   assign port_chg = |(port_rise | port_fall);
   assign t_on = timer_cfg[`ISL_C_ON];
   assign t_m16 = timer_cfg[`ISL_C_M16];
   assign t_wr = do_wr && wb0 && (wa[7:0] == `ISL_A_TLOW || wa[7:0] == `ISL_A_THIGH);
   always_comb begin
      if (t_m16) begin
         t_wrap = timer_zero_counter == `ISL_T16_MAX;
         next_timer = t_wrap ? 16'h0000 : timer_zero_counter + 16'h0001;
      end else begin
         t_wrap = timer_zero_counter[7:0] == `ISL_T8_MAX;
         next_timer = {timer_zero_counter[15:8], timer_zero_counter[7:0] + 8'h01};
      end
   end
   assign t_ovf = t_on && timer_tick && !t_wr && t_wrap;
   assign ev = {port_chg, t_ovf, ext_hit};

   // AXI write channel; address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= isl_pkg::ISL_RESP_OKAY;
         wa <= '0;
         wd <= '0;
         wb0 <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            wa <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wd <= wdata;
            wb0 <= wstrb[0];
            wready <= 1'b0;
         end
         if (do_wr) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= (wa[7:0] > `ISL_A_IMASK || wa[1:0] != 2'b00 || (wa >> 8) != '0) ?
                     isl_pkg::ISL_RESP_SLVERR : isl_pkg::ISL_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Flag registers: a hardware set wins over a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_control_main <= `ISL_RST_MAIN;
         irq_control_second <= `ISL_RST_SECOND;
         irq_control_third <= `ISL_RST_THIRD;
      end else if (ce) begin
         irq_control_main <= (wr_main ? wd[7:0] : irq_control_main)
                             | {5'h00, t_ovf, ext_hit[0], port_chg};
         if (do_wr && wb0 && wa[7:0] == `ISL_A_SECOND) begin
            irq_control_second <= wd[7:0];
         end
         irq_control_third <= ((do_wr && wb0 && wa[7:0] == `ISL_A_THIRD) ? wd[7:0] :
                               irq_control_third) | {6'h00, ext_hit[2:1]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_irq_flags_one <= `ISL_RST_PERIPH;
         periph_irq_enables_one <= `ISL_RST_PERIPH;
         periph_irq_priority_one <= `ISL_RST_PERIPH;
         periph_irq_flags_two <= `ISL_RST_PERIPH;
         periph_irq_enables_two <= `ISL_RST_PERIPH;
         periph_irq_priority_two <= `ISL_RST_PERIPH;
      end else if (ce) begin
         periph_irq_flags_one <= (((do_wr && wb0 && wa[7:0] == `ISL_A_PFLG1) ? wd[7:0] :
                                 periph_irq_flags_one) | {1'b0, periph_evt_one}) & `ISL_PMASK1;
         periph_irq_flags_two <= (((do_wr && wb0 && wa[7:0] == `ISL_A_PFLG2) ? wd[7:0] :
                                 periph_irq_flags_two) | {4'h0, periph_evt_two}) & `ISL_PMASK2;
         if (do_wr && wb0) begin
            case (wa[7:0])
               `ISL_A_PEN1: periph_irq_enables_one <= wd[7:0] & `ISL_PMASK1;
               `ISL_A_PPRI1: periph_irq_priority_one <= wd[7:0] & `ISL_PMASK1;
               `ISL_A_PEN2: periph_irq_enables_two <= wd[7:0] & `ISL_PMASK2;
               `ISL_A_PPRI2: periph_irq_priority_two <= wd[7:0] & `ISL_PMASK2;
               default: ;
            endcase
         end
      end
   end

   // Timer-0 counter; a software write wins over a count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_zero_counter <= 16'h0000;
         timer_cfg <= 2'h0;
      end else if (ce) begin
         if (do_wr && wb0 && wa[7:0] == `ISL_A_TLOW) begin
            timer_zero_counter[7:0] <= wd[7:0];
         end else if (do_wr && wb0 && wa[7:0] == `ISL_A_THIGH) begin
            timer_zero_counter[15:8] <= wd[7:0];
         end else if (t_on && timer_tick) begin
            timer_zero_counter <= next_timer;
         end
         if (do_wr && wb0 && wa[7:0] == `ISL_A_TCFG) begin
            timer_cfg <= wd[1:0];
         end
      end
   end

   // Request generation
   logic [4:0] src_act;
   logic [4:0] src_hi;
   logic per_hi;
   logic per_lo;
   logic high_level_global_enable;
   logic low_level_global_enable;
   logic next_high;
   logic next_low;
   logic next_wake;
   logic [2:0] ext_flag;

   assign high_level_global_enable = irq_control_main[`ISL_M_HIGH_LEVEL_GLOBAL_ENABLE];
   assign low_level_global_enable = irq_control_main[`ISL_M_LOW_LEVEL_GLOBAL_ENABLE];
   assign ext_flag = {irq_control_third[`ISL_T_E2IF], irq_control_third[`ISL_T_E1IF],
                      irq_control_main[`ISL_M_E0IF]};
   assign src_act = {irq_control_main[`ISL_M_PCIF] & irq_control_main[`ISL_M_PCIE],
                     irq_control_main[`ISL_M_T0IF] & irq_control_main[`ISL_M_T0IE],
                     ext_flag & {irq_control_third[`ISL_T_E2IE], irq_control_third[`ISL_T_E1IE],
                                 irq_control_main[`ISL_M_E0IE]}};
   assign src_hi = {irq_control_second[`ISL_S_PCIP], irq_control_second[`ISL_S_T0IP],
                    irq_control_third[`ISL_T_E2IP], irq_control_third[`ISL_T_E1IP],
                    1'b1};
   assign per_hi = |(periph_irq_flags_one & periph_irq_enables_one & periph_irq_priority_one)
                 | |(periph_irq_flags_two & periph_irq_enables_two & periph_irq_priority_two);
   assign per_lo = |(periph_irq_flags_one & periph_irq_enables_one & ~periph_irq_priority_one)
                 | |(periph_irq_flags_two & periph_irq_enables_two & ~periph_irq_priority_two);
   assign next_high = high_level_global_enable && (|(src_act & src_hi) || per_hi);
   assign next_low = high_level_global_enable && low_level_global_enable && (|(src_act & ~src_hi) || per_lo);
   assign next_wake = sleep_mode && |(ext_flag & en_snap);

   // Enables are frozen at sleep entry so a late enable does not wake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_prev <= 1'b0;
         en_snap <= 3'h0;
         irq_high_req <= 1'b0;
         irq_low_req <= 1'b0;
         wake_up <= 1'b0;
         vector_on_wake <= 1'b0;
      end else if (ce) begin
         sleep_prev <= sleep_mode;
         if (sleep_mode && !sleep_prev) begin
            en_snap <= {irq_control_third[`ISL_T_E2IE], irq_control_third[`ISL_T_E1IE],
                        irq_control_main[`ISL_M_E0IE]};
         end
         irq_high_req <= next_high;
         irq_low_req <= next_low;
         wake_up <= next_wake;
         vector_on_wake <= next_wake && high_level_global_enable;
      end
   end

   // Context capture on acknowledge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_push <= 1'b0;
         stack_push_pc <= 21'h000000;
         fast_working <= 8'h00;
         fast_status <= 8'h00;
         fast_bank <= 8'h00;
      end else if (ce) begin
         stack_push <= irq_ack;
         if (irq_ack) begin
            stack_push_pc <= core_pc;
            fast_working <= working_register;
            fast_status <= core_status;
            fast_bank <= bank_select_register;
         end
      end
   end

   // Sticky event status, write one to clear, masked onto irq
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_stat <= 5'h00;
         ev_mask <= 5'h00;
         irq <= 1'b0;
      end else if (ce) begin
         ev_stat <= (ev_stat & ~((do_wr && wb0 && wa[7:0] == `ISL_A_ISTAT) ? wd[4:0] : 5'h00))
                    | ev;
         if (do_wr && wb0 && wa[7:0] == `ISL_A_IMASK) begin
            ev_mask <= wd[4:0];
         end
         irq <= |(ev_stat & ev_mask);
      end
   end

   // AXI read channel
   function automatic logic [32:0] rd_mux(input logic [AW-1:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      if (a[1:0] == 2'b00 && (a >> 8) == '0) begin
         case (a[7:0])
            `ISL_A_MAIN: r = {25'h0, irq_control_main};
            `ISL_A_SECOND: r = {25'h0, irq_control_second};
            `ISL_A_THIRD: r = {25'h0, irq_control_third};
            `ISL_A_PFLG1: r = {25'h0, periph_irq_flags_one};
            `ISL_A_PEN1: r = {25'h0, periph_irq_enables_one};
            `ISL_A_PPRI1: r = {25'h0, periph_irq_priority_one};
            `ISL_A_PFLG2: r = {25'h0, periph_irq_flags_two};
            `ISL_A_PEN2: r = {25'h0, periph_irq_enables_two};
            `ISL_A_PPRI2: r = {25'h0, periph_irq_priority_two};
            `ISL_A_TLOW: r = {25'h0, timer_zero_counter[7:0]};
            `ISL_A_THIGH: r = {25'h0, timer_zero_counter[15:8]};
            `ISL_A_TCFG: r = {31'h0, timer_cfg};
            `ISL_A_ISTAT: r = {28'h0, ev_stat};
            `ISL_A_IMASK: r = {28'h0, ev_mask};
            `ISL_A_STATE: r = {29'h0, vector_on_wake, wake_up, irq_low_req, irq_high_req};
            default: r = {1'b1, 32'h0000_0000};
         endcase
      end
      return r;
   endfunction : rd_mux

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= isl_pkg::ISL_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            {rresp[1], rdata} <= rd_mux(araddr);
            rresp[0] <= 1'b0;
            rvalid <= 1'b1;
            arready <= 1'b0;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_edge_rise_flag: assert property (ce && ext_rise[0] && edge_sel[0] |=> ext_flag[0])
      else $error("rising edge did not set flag zero");
   a_edge_fall_flag: assert property (ce && ext_fall[1] && !edge_sel[1] |=> ext_flag[1])
      else $error("falling edge did not set flag one");
   a_flag_sticky_main: assert property (ext_flag[0] && !wr_main |=> ext_flag[0])
      else $error("flag zero dropped without a write");
   a_disabled_quiet: assert property (ce && !high_level_global_enable |=> !irq_high_req && !irq_low_req)
      else $error("request raised with global enable clear");
   a_ext_irq_zero_always_high: assert property (ce && high_level_global_enable && src_act[0] |=> irq_high_req)
      else $error("external zero not high priority");
   a_ext_disabled_req: assert property (ce && high_level_global_enable && src_act == 5'h00 && !per_hi |=> !irq_high_req)
      else $error("disabled source requested");
   a_wake_sleep: assert property (ce && sleep_mode && |(ext_flag & en_snap) |=> wake_up)
      else $error("no wake on enabled external flag");
   a_vector_gie: assert property (vector_on_wake |-> wake_up && $past(high_level_global_enable))
      else $error("vectored without global enable");
   a_timer8_wrap: assert property (ce && t_on && timer_tick && !t_wr && !t_m16
      && timer_zero_counter[7:0] == 8'hff |=> timer_zero_counter[7:0] == 8'h00
      && irq_control_main[`ISL_M_T0IF])
      else $error("8-bit wrap missed");
   a_timer16_wrap: assert property (ce && t_on && timer_tick && !t_wr && t_m16
      && timer_zero_counter == 16'h0fff |=> timer_zero_counter == 16'h0000
      && irq_control_main[`ISL_M_T0IF])
      else $error("16-bit wrap missed");
   a_port_change: assert property (ce && port_chg |=> irq_control_main[`ISL_M_PCIF])
      else $error("port change flag not set");
   a_ctx_push: assert property (ce && irq_ack |=> stack_push
      && stack_push_pc == $past(core_pc) && fast_bank == $past(bank_select_register))
      else $error("context not captured");

   c_wake_vector: cover property (ce && sleep_mode ##[1:20] vector_on_wake);
   c_low_req: cover property (irq_low_req && !irq_high_req);
   c_axi_write_read: cover property (bvalid && bready ##[1:10] rvalid && rready);
endmodule : isl_top

// file: testbench/isl_core_model.sv
// Behavioural core: runs a program counter, takes requests, enters sleep.
// Assumes aclk shared with the block; take_en and sleep_req come from the bench.
`timescale 1ns/100ps
module isl_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_high_req,
   input wire logic irq_low_req,
   input wire logic take_en,
   input wire logic sleep_req,
   output logic irq_ack,
   output logic sleep_mode,
   output logic [20:0] core_pc,
   output logic [7:0] working_register,
   output logic [7:0] core_status,
   output logic [7:0] bank_select_register,
   output logic [20:0] exp_pc
);
   logic taken;
   // PC, working and status move every cycle, so a capture on the wrong edge shows
   assign working_register = core_pc[7:0] ^ 8'h5a;
   assign core_status = ~core_pc[7:0];
   assign bank_select_register = core_pc[15:8];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_pc <= 21'h000000;
         sleep_mode <= 1'b0;
      end else begin
         core_pc <= core_pc + 21'h000001;
         sleep_mode <= sleep_req;
      end
   end
   // One acknowledge per take_en window; request level stays up until software clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack <= 1'b0;
         taken <= 1'b0;
         exp_pc <= 21'h000000;
      end else begin
         irq_ack <= 1'b0;
         if (irq_ack) begin
            exp_pc <= core_pc;
         end
         if (!take_en) begin
            taken <= 1'b0;
         end else if (!taken && (irq_high_req || irq_low_req)) begin
            irq_ack <= 1'b1;
            taken <= 1'b1;
         end
      end
   end
endmodule : isl_core_model

// file: testbench/isl_top_tb_top.sv
// Self-checking bench: AXI4-Lite register tasks, pin and core stimulus.
// Assumes the block and the core model share aclk at 200 MHz.
`timescale 1ns/100ps
`include "isl_cfg.svh"
module isl_top_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic timer_tick = 1'b0, take_en = 1'b0, sleep_req = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hf, port_b_high = 4'h0, periph_evt_two = 4'h0;
   logic [2:0] ext_irq_pin = 3'h0;
   logic [6:0] periph_evt_one = 7'h00;
   logic awready, wready, bvalid, arready, rvalid, irq_ack, sleep_mode;
   logic irq_high_req, irq_low_req, wake_up, vector_on_wake, stack_push, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata;
   logic [20:0] core_pc, stack_push_pc, exp_pc;
   logic [7:0] working_register, core_status, bank_select_register, d;
   logic [7:0] fast_working, fast_status, fast_bank;
   int n_fail = 0, num_checks = 0, cyc = 0;
   isl_top isl_top_i (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .ext_irq_pin, .port_b_high, .timer_tick, .periph_evt_one,
      .periph_evt_two, .sleep_mode, .irq_ack, .core_pc, .working_register, .core_status,
      .bank_select_register, .irq_high_req, .irq_low_req, .wake_up, .vector_on_wake,
      .stack_push, .stack_push_pc, .fast_working, .fast_status, .fast_bank, .irq);
   isl_core_model isl_core_model_i (.aclk, .aresetn, .irq_high_req, .irq_low_req, .take_en,
      .sleep_req, .irq_ack, .sleep_mode, .core_pc, .working_register, .core_status,
      .bank_select_register, .exp_pc);
   always #2.5 aclk = ~aclk;
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bit ad;
      bit dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         ad = ad | awready;
         dd = dd | wready;
         if (ad) awvalid <= 1'b0;
         if (dd) wvalid <= 1'b0;
      end
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata[7:0];
      rs = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a, d, r);
      chk(d, e);
   endtask : rchk
   // Pin latency is two sync stages, compare and flag register
   task automatic run(input int n);
      repeat (n) @(posedge aclk);
   endtask : run
   task automatic tick(input int n);
      timer_tick <= 1'b1;
      run(n);
      timer_tick <= 1'b0;
      run(2);
   endtask : tick
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      int k;
      run(20);
      aresetn <= 1'b1;
      rchk(`ISL_A_MAIN, 8'h00);
      rd(8'h3c, d, r);
      chk(r, isl_pkg::ISL_RESP_SLVERR);
      for (k = 0; k < 4; k++) begin
         wr(`ISL_A_SECOND, k[1] ? 8'h70 : 8'h00);
         wr(`ISL_A_MAIN, 8'h00);
         wr(`ISL_A_THIRD, 8'h00);
         ext_irq_pin <= ~ext_irq_pin;
         run(6);
         rchk(`ISL_A_MAIN, (k == 1 || k == 2) ? 8'h02 : 8'h00);
         rchk(`ISL_A_THIRD, (k == 1 || k == 2) ? 8'h03 : 8'h00);
      end
      ext_irq_pin <= 3'h7;
      run(6);
      chk({irq_high_req, irq_low_req}, 2'b00);
      wr(`ISL_A_MAIN, 8'h92);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b10);
      wr(`ISL_A_MAIN, 8'h82);
      wr(`ISL_A_THIRD, 8'h0b);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b00);
      wr(`ISL_A_MAIN, 8'hc2);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b01);
      wr(`ISL_A_THIRD, 8'h4b);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b10);
      take_en <= 1'b1;
      run(4);
      chk(stack_push_pc, exp_pc);
      chk({fast_working, fast_status, fast_bank},
         {exp_pc[7:0] ^ 8'h5a, ~exp_pc[7:0], exp_pc[15:8]});
      take_en <= 1'b0;
      rchk(`ISL_A_THIRD, 8'h4b);
      wr(`ISL_A_THIRD, 8'h48);
      run(2);
      chk(irq_high_req, 1'b0);
      wr(`ISL_A_MAIN, 8'h00);
      wr(`ISL_A_TLOW, 8'hfe);
      wr(`ISL_A_TCFG, 8'h01);
      tick(1);
      rchk(`ISL_A_MAIN, 8'h00);
      tick(1);
      rchk(`ISL_A_MAIN, 8'h04);
      wr(`ISL_A_MAIN, 8'h00);
      wr(`ISL_A_THIGH, 8'h0f);
      wr(`ISL_A_TLOW, 8'hfe);
      wr(`ISL_A_TCFG, 8'h03);
      tick(1);
      rchk(`ISL_A_MAIN, 8'h00);
      tick(1);
      rchk(`ISL_A_MAIN, 8'h04);
      wr(`ISL_A_TCFG, 8'h00);
      wr(`ISL_A_MAIN, 8'ha4);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b00);
      wr(`ISL_A_SECOND, 8'h74);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b10);
      wr(`ISL_A_MAIN, 8'h00);
      port_b_high <= 4'h8;
      run(6);
      rchk(`ISL_A_MAIN, 8'h01);
      wr(`ISL_A_MAIN, 8'hc9);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b01);
      rchk(`ISL_A_ISTAT, 8'h1f);
      chk(irq, 1'b0);
      wr(`ISL_A_IMASK, 8'h10);
      run(3);
      chk(irq, 1'b1);
      wr(`ISL_A_ISTAT, 8'h10);
      run(3);
      chk(irq, 1'b0);
      rchk(`ISL_A_ISTAT, 8'h0f);
      wr(`ISL_A_MAIN, 8'h10);
      ext_irq_pin <= 3'h0;
      sleep_req <= 1'b1;
      run(6);
      ext_irq_pin <= 3'h1;
      run(6);
      chk({wake_up, vector_on_wake}, 2'b10);
      wr(`ISL_A_MAIN, 8'h92);
      run(2);
      chk(vector_on_wake, 1'b1);
      sleep_req <= 1'b0;
      wr(`ISL_A_MAIN, 8'h80);
      wr(`ISL_A_PEN1, 8'h01);
      wr(`ISL_A_PPRI1, 8'h01);
      run(2);
      chk({irq_high_req, irq_low_req}, 2'b00);
      periph_evt_one <= 7'h01;
      run(1);
      periph_evt_one <= 7'h00;
      run(3);
      chk({irq_high_req, irq_low_req}, 2'b10);
      rchk(`ISL_A_PFLG1, 8'h01);
      final_report();
   end
endmodule : isl_top_tb_top
